// ===== shared/smb_alert_pkg.sv
// shared constants for the address decode, bus timeouts and alert masking
package smb_alert_pkg;
    // alert mask register command code and width
    localparam logic [7:0] CMD_FAULT_MASK = 8'hd8;
    localparam logic [7:0] CMD_CLEAR_FAULT = 8'h03;
    localparam int FAULT_W = 16;
    localparam logic [15:0] FAULT_MASK_RESET = 16'h0000;
    // alert response address (7 bit)
    localparam logic [6:0] ARA_ADDR = 7'h0c;
    // three-level pin codes
    localparam logic [1:0] PIN_LOW = 2'h0;
    localparam logic [1:0] PIN_HIGH = 2'h1;
    localparam logic [1:0] PIN_FLOAT = 2'h2;
    // timing, clock at 100 MHz
    localparam int CLK_MHZ = 100;
    localparam int TIMEOUT_MS = 25;
    localparam int SLAVE_EXT_MS = 25;
    localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000 * CLK_MHZ;
    localparam int SLAVE_EXT_CYC = SLAVE_EXT_MS * 1000 * CLK_MHZ;
    localparam int CNT_W = 22;
    // pin address lookup, index = addr_select_pin_2*9 + addr_select_pin_1*3 + addr_select_pin_0 with float=0, low=1, high=2
    localparam logic [6:0] ADDR_LUT [0:26] = '{
        7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46, 7'h47, 7'h10,
        7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17, 7'h50, 7'h51,
        7'h52, 7'h53, 7'h54, 7'h55, 7'h56, 7'h57, 7'h58, 7'h59, 7'h5a};
endpackage : smb_alert_pkg

// ===== shared/addr_if.sv
// address selection handshake between the pin sampler and the bus slave
`timescale 1ns/1ps
interface addr_if;
    logic valid;
    logic [6:0] addr;
    modport src (output valid, output addr);
    modport dst (input valid, input addr);
endinterface : addr_if

// ===== hw/addr_sel.sv
// three-level address pin sampler and lookup
`timescale 1ns/1ps
module addr_sel
    import smb_alert_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sample_ok,
    input wire logic [1:0] pin_code [3],
    addr_if.src out
);
    logic [4:0] idx;
    logic [1:0] t [3];
    logic valid_q;
    logic [6:0] addr_q;

    // float maps to digit 0 so the all-open pattern hits entry zero
    genvar g;
    for (g = 0; g < 3; g++) begin : g_dig
        assign t[g] = (pin_code[g] == PIN_FLOAT) ? 2'h0 :
                      (pin_code[g] == PIN_LOW) ? 2'h1 : 2'h2;
    end
    assign idx = 5'(t[2] * 9 + t[1] * 3 + t[0]);

    // latched once; later pin motion is ignored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            valid_q <= 1'b0;
            addr_q <= 7'h00;
        end else if (sample_ok && !valid_q) begin
            valid_q <= 1'b1;
            addr_q <= ADDR_LUT[idx];
        end
    end
    assign out.valid = valid_q;
    assign out.addr = addr_q;
endmodule : addr_sel

// ===== hw/smb_alert_slave.sv
// smbus slave with pin address, timeouts and alert masking
`timescale 1ns/1ps
//
// Operation
// - each address pin has three levels
// - latch pins after enable and power-good
// - fixed lookup to seven-bit address
// - clock low over 25 ms resets interface
// - own stretching capped at 25 ms
// - alert gated by mask register and auto-mask
// - lowest alerting address wins response read
// - release alert after own address returned
// - auto-mask all faults present at read
// - auto-mask leaves status untouched
// - auto-mask cleared only by clear fault
module smb_alert_slave
    import smb_alert_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic por_done,
    input wire logic [1:0] addr_select_pin_0,
    input wire logic [1:0] addr_select_pin_1,
    input wire logic [1:0] addr_select_pin_2,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic stretch_req,
    input wire logic [15:0] fault_status,
    output logic [15:0] status_out,
    output logic alert_oe,
    output logic [6:0] slave_addr,
    output logic addr_valid
);
    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_ADDR = 6'b000010,
        S_ACK = 6'b000100,
        S_RX = 6'b001000,
        S_TX = 6'b010000,
        S_WAIT = 6'b100000
    } st_e;

    // two-flop synchronisers for every pin input
    logic [1:0] scl_s, sda_s, en_s, por_s;
    logic [1:0] p0_a, p0_b, p1_a, p1_b, p2_a, p2_b;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_s <= 2'h3;
            sda_s <= 2'h3;
            en_s <= 2'h0;
            por_s <= 2'h0;
            p0_a <= 2'h0;
            p0_b <= 2'h0;
            p1_a <= 2'h0;
            p1_b <= 2'h0;
            p2_a <= 2'h0;
            p2_b <= 2'h0;
        end else begin
            scl_s <= {scl_s[0], scl_i};
            sda_s <= {sda_s[0], sda_i};
            en_s <= {en_s[0], enable};
            por_s <= {por_s[0], por_done};
            p0_a <= addr_select_pin_0;
            p0_b <= p0_a;
            p1_a <= addr_select_pin_1;
            p1_b <= p1_a;
            p2_a <= addr_select_pin_2;
            p2_b <= p2_a;
        end
    end

    // edge detection works on the second stage only
    logic scl_q, sda_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s[1];
            sda_q <= sda_s[1];
        end
    end
    wire scl_rise = scl_s[1] && !scl_q;
    wire scl_fall = !scl_s[1] && scl_q;
    wire start_c = scl_s[1] && scl_q && !sda_s[1] && sda_q;
    wire stop_c = scl_s[1] && scl_q && sda_s[1] && !sda_q;

    // address sampler
    addr_if aif ();
    logic [1:0] pins [3];
    assign pins[0] = p0_b;
    assign pins[1] = p1_b;
    assign pins[2] = p2_b;
    wire sample_ok = en_s[1] && por_s[1];
    addr_sel u_addr (
        .clk(clk),
        .rst_n(rst_n),
        .sample_ok(sample_ok),
        .pin_code(pins),
        .out(aif.src)
    );

    st_e st_q, st_d;
    logic [7:0] sh_q;
    logic [3:0] bit_q;
    logic rw_q, ara_q, lost_q, mine_q;
    logic [1:0] byte_q;
    logic [7:0] cmd_q;
    logic [15:0] mask_q, auto_q;
    logic [CNT_W-1:0] low_cnt_q;
    logic [CNT_W:0] ext_cnt_q;
    logic sda_oe_q, scl_oe_q, alert_q, stretch_q;

    // bus timeouts: long clock low, or own stretch budget used up
    wire low_to = low_cnt_q >= CNT_W'(TIMEOUT_CYC);
    wire ext_to = ext_cnt_q >= (CNT_W+1)'(SLAVE_EXT_CYC);
    wire abort = low_to || ext_to;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) low_cnt_q <= '0;
        else if (scl_s[1] || st_q == S_IDLE) low_cnt_q <= '0;
        else if (!low_to) low_cnt_q <= low_cnt_q + 1'b1;
    end
    // cumulative per message, start to stop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) ext_cnt_q <= '0;
        else if (start_c || stop_c) ext_cnt_q <= '0;
        else if (scl_oe_q && !ext_to) ext_cnt_q <= ext_cnt_q + 1'b1;
    end

    // address match includes the alert response address when alerting
    // after eight shifts the address sits above the read/write bit
    wire [6:0] rx_addr = sh_q[7:1];
    wire hit_own = aif.valid && rx_addr == aif.addr;
    wire hit_ara = rx_addr == ARA_ADDR && alert_q;
    wire [15:0] live = fault_status & ~mask_q & ~auto_q;

    // receive and transmit sequencing
    always_comb begin
        st_d = st_q;
        case (st_q)
            S_IDLE: if (start_c) st_d = S_ADDR;
            S_ADDR: if (scl_fall && bit_q == 4'h8)
                st_d = (hit_own || hit_ara) ? S_ACK : S_WAIT;
            S_ACK: if (scl_fall) st_d = rw_q ? S_TX : S_RX;
            S_RX: if (scl_fall && bit_q == 4'h8) st_d = S_ACK;
            S_TX: if (scl_fall && (bit_q == 4'h8 || lost_q)) st_d = S_WAIT;
            S_WAIT: st_d = S_WAIT;
            default: st_d = S_IDLE;
        endcase
        if (stop_c || abort) st_d = S_IDLE;
        else if (start_c) st_d = S_ADDR;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) st_q <= S_IDLE;
        else st_q <= st_d;
    end

    // shift register, bit counter and byte bookkeeping
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sh_q <= 8'h00;
            bit_q <= 4'h0;
            rw_q <= 1'b0;
            ara_q <= 1'b0;
            byte_q <= 2'h0;
            cmd_q <= 8'h00;
            lost_q <= 1'b0;
            mine_q <= 1'b0;
        end else if (st_d == S_ADDR && st_q != S_ADDR) begin
            bit_q <= 4'h0;
            byte_q <= 2'h0;
            lost_q <= 1'b0;
        end else if (st_q == S_ADDR && scl_rise) begin
            sh_q <= {sh_q[6:0], sda_s[1]};
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'h7) begin
                rw_q <= sda_s[1];
                // seven address bits are in the low end before the eighth shift
                ara_q <= sh_q[6:0] == ARA_ADDR && !(aif.valid && sh_q[6:0] == aif.addr);
            end
        end else if (st_q == S_ACK && scl_fall) begin
            bit_q <= 4'h0;
            if (rw_q) sh_q <= {1'b0, aif.addr};
        end else if (st_q == S_RX && scl_rise) begin
            sh_q <= {sh_q[6:0], sda_s[1]};
            bit_q <= bit_q + 4'h1;
        end else if (st_q == S_RX && scl_fall && bit_q == 4'h8) begin
            byte_q <= byte_q + 2'h1;
            if (byte_q == 2'h0) cmd_q <= sh_q;
        end else if (st_q == S_TX && scl_rise) begin
            // sent a one but the wire is low: another slave wins
            if (sh_q[7] && !sda_s[1]) lost_q <= 1'b1;
            bit_q <= bit_q + 4'h1;
            mine_q <= bit_q == 4'h7 && !lost_q && !(sh_q[7] && !sda_s[1]);
        end else if (st_q == S_TX && scl_fall) begin
            // next bit only moves while the clock is low, never mid-high
            sh_q <= {sh_q[6:0], 1'b0};
        end else begin
            mine_q <= 1'b0;
        end
    end

    // mask register writes, clear fault, and automatic masking
    wire wr_lo = st_q == S_RX && scl_fall && bit_q == 4'h8 && byte_q == 2'h1;
    wire wr_hi = st_q == S_RX && scl_fall && bit_q == 4'h8 && byte_q == 2'h2;
    wire clr_f = st_q == S_RX && scl_fall && bit_q == 4'h8 && byte_q == 2'h0
                 && sh_q == CMD_CLEAR_FAULT;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= FAULT_MASK_RESET;
            auto_q <= 16'h0000;
        end else begin
            if (wr_lo && cmd_q == CMD_FAULT_MASK) mask_q[7:0] <= sh_q;
            if (wr_hi && cmd_q == CMD_FAULT_MASK) mask_q[15:8] <= sh_q;
            // a fresh win beats a same-cycle clear
            if (mine_q && ara_q) auto_q <= auto_q | fault_status;
            else if (clr_f) auto_q <= 16'h0000;
        end
    end

    // pin drivers: data low for ack and zero bits, clock held low for stretch
    // the ack phase is always ours: address ack on reads and writes, byte ack on writes
    wire ack_drv = st_q == S_ACK;
    // hold the last bit through its high phase; release comes with the state change
    wire tx_drv = st_q == S_TX && !lost_q && !sh_q[7];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_oe_q <= 1'b0;
            scl_oe_q <= 1'b0;
            alert_q <= 1'b0;
            stretch_q <= 1'b0;
        end else begin
            sda_oe_q <= !abort && (ack_drv || tx_drv);
            stretch_q <= stretch_req;
            // grab the clock only at a seen falling edge, so a high phase is never cut
            scl_oe_q <= !abort && stretch_q && st_q != S_IDLE && (scl_oe_q || scl_fall);
            alert_q <= |live;
        end
    end

    // status passes straight through; masks never touch it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_out <= 16'h0000;
            slave_addr <= 7'h00;
            addr_valid <= 1'b0;
        end else begin
            status_out <= fault_status;
            slave_addr <= aif.addr;
            addr_valid <= aif.valid;
        end
    end

    assign sda_o = 1'b0;
    assign scl_o = 1'b0;
    assign sda_oe = sda_oe_q;
    assign scl_oe = scl_oe_q;
    assign alert_oe = alert_q;
endmodule : smb_alert_slave

// ===== sim/smb_host_model.sv
// host controller model: open-drain bus lines, 160 ns bit period
`timescale 1ns/1ps
module smb_host_model (
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_d = 1'b1,
    output logic sda_d = 1'b1
);
    // start: data falls while clock is high, after a bus free gap
    task automatic start();
        #80 sda_d = 1'b0;
        #80 scl_d = 1'b0;
    endtask : start
    // one bit, clock stands still between frames
    task automatic bit_io(input logic b, output logic r);
        #40 sda_d = b;
        #40 scl_d = 1'b1;
        wait (scl_i === 1'b1); // slave may stretch
        #40 r = sda_i;
        #40 scl_d = 1'b0;
    endtask : bit_io
    // byte msb first, ninth bit released so a read ends in nack
    task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic a);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
            q[i] = r;
        end
        bit_io(1'b1, a);
    endtask : xfer
    // stop: data rises while clock is high
    task automatic stop();
        #40 sda_d = 1'b0;
        #40 scl_d = 1'b1;
        #80 sda_d = 1'b1;
    endtask : stop
endmodule : smb_host_model

// ===== sim/smb_alert_slave_sva.sv
// concurrent checks on address latch, status copy and alert pin
`timescale 1ns/1ps
module smb_alert_slave_sva
    import smb_alert_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic por_done,
    input wire logic [1:0] addr_select_pin_0,
    input wire logic [1:0] addr_select_pin_1,
    input wire logic [1:0] addr_select_pin_2,
    input wire logic [15:0] fault_status,
    input wire logic [15:0] status_out,
    input wire logic alert_oe,
    input wire logic [6:0] slave_addr,
    input wire logic addr_valid,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic stretch_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // pin codes as {pin 2, pin 1, pin 0}: 2 float, 1 high, 0 low
    wire [5:0] pv = {addr_select_pin_2, addr_select_pin_1, addr_select_pin_0};
    chk_addr_float: assert property (
        $rose(addr_valid) && pv == 6'h2a |-> slave_addr == 7'h40) else $error("float addr");
    chk_addr_high: assert property (
        $rose(addr_valid) && pv == 6'h15 |-> slave_addr == 7'h5a) else $error("high addr");
    chk_addr_mixed: assert property (
        $rose(addr_valid) && pv == 6'h25 |-> slave_addr == 7'h10) else $error("mixed addr");
    chk_addr_held: assert property (addr_valid |=> addr_valid && $stable(slave_addr))
        else $error("address moved");
    chk_addr_gate: assert property ($rose(addr_valid) |-> $past(enable, 2) && $past(por_done, 2))
        else $error("address early");
    chk_status_copy: assert property ($stable(fault_status)[*4] |-> status_out == fault_status)
        else $error("status differs");
    chk_alert_cause: assert property ((fault_status == 16'h0000)[*6] |-> !alert_oe)
        else $error("alert without fault");
    chk_sda_drain: assert property (sda_oe |-> sda_o == 1'b0 && addr_valid)
        else $error("sda not open drain");
    chk_scl_drain: assert property (scl_oe |-> scl_o == 1'b0)
        else $error("scl not open drain");
    chk_stretch_req: assert property (scl_oe |-> $past(stretch_req, 2))
        else $error("clock held without request");
endmodule : smb_alert_slave_sva
bind smb_alert_slave smb_alert_slave_sva u_sva (
    .clk(clk),
    .rst_n(rst_n),
    .enable(enable),
    .por_done(por_done),
    .addr_select_pin_0(addr_select_pin_0),
    .addr_select_pin_1(addr_select_pin_1),
    .addr_select_pin_2(addr_select_pin_2),
    .fault_status(fault_status),
    .status_out(status_out),
    .alert_oe(alert_oe),
    .slave_addr(slave_addr),
    .addr_valid(addr_valid),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .scl_o(scl_o),
    .scl_oe(scl_oe),
    .stretch_req(stretch_req)
);

// ===== sim/smb_alert_slave_tb.sv
// bench: pin address decode, mask writes and alert response reads
`timescale 1ns/1ps
module smb_alert_slave_tb;
    import smb_alert_pkg::*;
    logic clk = 1'b0, stretch_req = 1'b0, rst_n, enable, por_done;
    logic [1:0] addr_select_pin_0, addr_select_pin_1, addr_select_pin_2;
    logic [15:0] fault_status = 16'h0000, status_out;
    logic [6:0] slave_addr;
    logic addr_valid, alert_oe, scl_o, scl_oe, sda_o, sda_oe, scl_d, sda_d, ack, junk;
    logic [7:0] rd;
    int err_count = 0, total_checks = 0;
    // {pin 2, pin 1, pin 0} with 2 float, 1 high, 0 low, and the address chosen
    localparam logic [5:0] PINS [6] = '{6'h25, 6'h15, 6'h00, 6'h04, 6'h18, 6'h2a};
    localparam logic [15:0] ADRS [6] = '{16'h10, 16'h5a, 16'h15, 16'h50, 16'h53, 16'h40};
    // pulled-up wires, low while any party pulls
    wire scl_i = scl_oe ? scl_o : scl_d;
    wire sda_i = sda_oe ? sda_o : sda_d;
    always #5 clk = ~clk;
    smb_alert_slave u_dut (
        .clk(clk),
        .rst_n(rst_n),
        .enable(enable),
        .por_done(por_done),
        .addr_select_pin_0(addr_select_pin_0),
        .addr_select_pin_1(addr_select_pin_1),
        .addr_select_pin_2(addr_select_pin_2),
        .scl_i(scl_i),
        .scl_o(scl_o),
        .scl_oe(scl_oe),
        .sda_i(sda_i),
        .sda_o(sda_o),
        .sda_oe(sda_oe),
        .stretch_req(stretch_req),
        .fault_status(fault_status),
        .status_out(status_out),
        .alert_oe(alert_oe),
        .slave_addr(slave_addr),
        .addr_valid(addr_valid)
    );
    smb_host_model u_host (
        .scl_i(scl_i),
        .sda_i(sda_i),
        .scl_d(scl_d),
        .sda_d(sda_d)
    );
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    // one message: address byte then n more, word low byte first
    task automatic xact(input logic [7:0] a, input logic [7:0] c,
                        input logic [15:0] w, input int n);
        u_host.start();
        u_host.xfer(a, rd, ack);
        if (n > 0) u_host.xfer(c, rd, junk);
        if (n > 1) u_host.xfer(w[7:0], rd, junk);
        if (n > 2) u_host.xfer(w[15:8], rd, junk);
        u_host.stop();
        repeat (12) @(negedge clk);
    endtask : xact
    // new live faults, settle, then look at the alert pin
    task automatic fault(input logic [15:0] f, input logic e);
        fault_status = f;
        repeat (12) @(negedge clk);
        check({15'h0000, alert_oe}, {15'h0000, e});
    endtask : fault
    // a power-up per pin pattern, then bus traffic on address 40h
    initial begin
        for (int k = 0; k < 6; k++) begin
            {rst_n, enable, por_done} = 3'b000;
            {addr_select_pin_2, addr_select_pin_1, addr_select_pin_0} = PINS[k];
            repeat (4) @(negedge clk);
            rst_n = 1'b1;
            @(negedge clk);
            {enable, por_done} = 2'b11;
            for (int i = 0; i < 20 && addr_valid !== 1'b1; i++) @(negedge clk);
            check({9'h000, slave_addr}, ADRS[k]);
        end
        {addr_select_pin_2, addr_select_pin_1, addr_select_pin_0} = 6'h00;
        xact(8'h82, CMD_CLEAR_FAULT, 16'h0000, 1);
        check({9'h000, slave_addr}, 16'h0040);
        check({15'h0000, ack}, 16'h0001);
        fault(16'h0005, 1'b1);
        xact(8'h80, CMD_FAULT_MASK, 16'h0005, 3);
        fault(16'h0005, 1'b0);
        // unmask while the slave holds the clock low for a while mid-message
        fork
            xact(8'h80, CMD_FAULT_MASK, 16'h0000, 3);
            begin
                repeat (300) @(negedge clk);
                stretch_req = 1'b1;
                repeat (200) @(negedge clk);
                stretch_req = 1'b0;
            end
        join
        fault(16'h0005, 1'b1);
        xact({ARA_ADDR, 1'b1}, 8'hff, 16'h0000, 1);
        check({8'h00, rd}, 16'h0040);
        check(status_out, 16'h0005);
        fault(16'h0005, 1'b0);
        fault(16'h0004, 1'b0);
        fault(16'h000d, 1'b1);
        xact({ARA_ADDR, 1'b1}, 8'hff, 16'h0000, 1);
        fault(16'h000d, 1'b0);
        xact({ARA_ADDR, 1'b1}, 8'hff, 16'h0000, 1);
        check({15'h0000, ack}, 16'h0001);
        xact(8'h80, CMD_CLEAR_FAULT, 16'h0000, 1);
        fault(16'h000d, 1'b1);
        give_verdict();
    end
    // traffic needs about 33 us; far beyond that means a hang
    initial begin
        #500us;
        err_count++;
        $display("Error at %0t: watchdog expired", $time);
        give_verdict();
    end
endmodule : smb_alert_slave_tb
